/* File: rtl/ussf_pkg.sv */
// Package for the engine status flag block: offsets, fields, reset values
// Summary of operation
// - Device: SETUP then DATA1 sets toggle fault
// - Device: OUT PID mismatch sets toggle fault
// - Host: wrong IN data PID sets toggle fault
// - Any ACK received sets acknowledge-seen flag
// - Missing ACK within turnaround sets timeout
// - Receive data too fast sets overrun flag
// - Bit stuffing violation sets stuffing flag
// - CRC failure sets checksum fault flag
// - Device: host bus reset sets reset flag
// - Device: final-buffer IN/OUT sets transfer done
// - Host: setup-only, final/zero IN, final OUT done
// - Device: SETUP received sets setup-arrived flag
// - Remote wakeup or host resume sets resume
// - Overcurrent bit follows external detection input
// - Host speed field: 00 none, 01 LS, 10 FS
// - Suspend entry sets suspend flag, either role
// - Role bit: 0 device, 1 host
// - Host SOF enable or keep-alive enable prevents suspend
package ussf_pkg;
    localparam logic [11:0] USSF_STATUS_OFS = 12'h050;
    localparam logic [11:0] USSF_CTRL_OFS = 12'h04C;
    localparam logic [11:0] USSF_MAIN_OFS = 12'h040;
    localparam int USSF_ROLE_BIT = 1;
    localparam int USSF_SOF_EN_BIT = 9;
    localparam int USSF_KEEP_EN_BIT = 10;
    localparam int USSF_TOGGLE_BIT = 31;
    localparam int USSF_ACK_BIT = 30;
    localparam int USSF_STALL_BIT = 29;
    localparam int USSF_NAK_BIT = 28;
    localparam int USSF_TIMEOUT_BIT = 27;
    localparam int USSF_OVERRUN_BIT = 26;
    localparam int USSF_STUFF_BIT = 25;
    localparam int USSF_CRC_BIT = 24;
    localparam int USSF_BUSRST_BIT = 19;
    localparam int USSF_DONE_BIT = 18;
    localparam int USSF_SETUP_BIT = 17;
    localparam int USSF_ATTACH_BIT = 16;
    localparam int USSF_RESUME_BIT = 11;
    localparam int USSF_OVERCUR_BIT = 10;
    localparam int USSF_SPEED_LSB = 8;
    localparam int USSF_SUSPEND_BIT = 4;
    localparam int USSF_LINE_LSB = 2;
    localparam int USSF_VBUS_BIT = 0;
    localparam logic [31:0] USSF_STICKY_MASK = 32'hFF0F_0B10;
    localparam logic [31:0] USSF_STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] USSF_CTRL_RST = 32'h0000_0000;
    localparam logic [1:0] USSF_SPEED_NONE = 2'h0;
    localparam logic [1:0] USSF_SPEED_LS = 2'h1;
    localparam logic [1:0] USSF_SPEED_FS = 2'h2;
    // Line state encodings as seen on the differential pair
    localparam logic [1:0] USSF_LINE_J = 2'h1;
    localparam logic [1:0] USSF_LINE_K = 2'h2;
    // Turnaround limit held as ns; plain default, tune per bus speed
    localparam int USSF_TURN_NS = 1500;
    localparam int USSF_CLK_NS = 20;
    localparam int USSF_TURN_CYC = USSF_TURN_NS / USSF_CLK_NS;
    typedef enum logic [1:0] {
        USSF_ST_IDLE = 2'b00,
        USSF_ST_WAIT_ACK = 2'b01,
        USSF_ST_SETUP_DATA = 2'b10
    } ussf_state_e;
endpackage

/* File: rtl/ussf_evt_if.sv */
// Interface carrying the one-cycle event set vector to the flag register
`timescale 1ns/1ps
interface ussf_evt_if;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] flags;
    modport src (output set_vec, output clr_vec, input flags);
    modport dst (input set_vec, input clr_vec, output flags);
endinterface

/* File: rtl/ussf_flag_reg.sv */
// Sticky write-one-to-clear flag register, set beats clear
`timescale 1ns/1ps
module ussf_flag_reg
    import ussf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    ussf_evt_if.dst evt
);
    typedef struct packed {
        logic [31:0] flags;
    } ussf_flag_s;
    ussf_flag_s st_q;
    ussf_flag_s st_d;

    // Event set wins over a clear landing in the same cycle
    always_comb begin
        st_d = st_q;
        st_d.flags = ((st_q.flags & ~evt.clr_vec) | evt.set_vec)
            & USSF_STICKY_MASK;
    end

    // Only sticky positions are stored here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{flags: USSF_STATUS_RST};
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign evt.flags = st_q.flags;
endmodule // ussf_flag_reg

/* File: rtl/ussf_status.sv */
// Engine status word with APB slave and event-to-flag logic
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ussf_status
    import ussf_pkg::*;
#(
    parameter int TURN_CYC = USSF_TURN_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pid_valid,
    input wire logic rx_is_setup,
    input wire logic rx_is_out,
    input wire logic rx_is_in,
    input wire logic rx_is_data,
    input wire logic rx_data1,
    input wire logic rx_data_len_zero,
    input wire logic rx_is_ack,
    input wire logic rx_is_nak,
    input wire logic rx_is_stall,
    input wire logic tx_data_done,
    input wire logic tx_setup_done,
    input wire logic setup_no_data,
    input wire logic ack_expected,
    input wire logic buf_toggle1,
    input wire logic final_buffer_marker,
    input wire logic rx_overrun,
    input wire logic rx_stuff_err,
    input wire logic rx_crc_err,
    input wire logic line_bus_reset,
    input wire logic line_resume,
    input wire logic line_suspend,
    input wire logic line_connect,
    input wire logic [1:0] line_state,
    input wire logic dev_low_speed,
    input wire logic supply_overcurrent_in,
    input wire logic supply_present_in,
    output logic role_select_bit,
    output logic bus_suspended
);
    typedef struct packed {
        logic [31:0] main_ctrl;
        logic [31:0] sie_ctrl;
        logic [31:0] rdata;
        logic [1:0] speed;
        ussf_state_e state;
        logic [15:0] turn_cnt;
        logic setup_seen;
    } ussf_core_s;
    ussf_core_s st_q;
    ussf_core_s st_d;
    ussf_evt_if evt ();

    // Register address decode reused for read and write
    function automatic logic [1:0] reg_sel(input logic [11:0] a);
        case (a)
            USSF_MAIN_OFS: reg_sel = 2'h1;
            USSF_CTRL_OFS: reg_sel = 2'h2;
            USSF_STATUS_OFS: reg_sel = 2'h3;
            default: reg_sel = 2'h0;
        endcase
    endfunction

    logic host;
    logic access;
    logic wr;
    logic timeout;
    logic [31:0] set_v;
    logic [31:0] live;

    assign host = st_q.main_ctrl[USSF_ROLE_BIT];
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign timeout = (st_q.state == USSF_ST_WAIT_ACK)
        && (st_q.turn_cnt >= 16'(TURN_CYC - 1));

    // Event sources mapped onto their status positions
    always_comb begin
        set_v = 32'h0000_0000;
        set_v[USSF_TOGGLE_BIT] = rx_pid_valid && rx_is_data && (
            (!host && st_q.setup_seen && rx_data1) ||
            (!host && rx_is_out && (rx_data1 != buf_toggle1)) ||
            (host && rx_is_in && (rx_data1 != buf_toggle1)));
        set_v[USSF_ACK_BIT] = rx_pid_valid && rx_is_ack;
        set_v[USSF_STALL_BIT] = host && rx_pid_valid && rx_is_stall;
        set_v[USSF_NAK_BIT] = host && rx_pid_valid && rx_is_nak;
        set_v[USSF_TIMEOUT_BIT] = timeout;
        set_v[USSF_OVERRUN_BIT] = rx_overrun;
        set_v[USSF_STUFF_BIT] = rx_stuff_err;
        set_v[USSF_CRC_BIT] = rx_crc_err;
        set_v[USSF_BUSRST_BIT] = !host && line_bus_reset;
        set_v[USSF_DONE_BIT] =
            (!host && tx_data_done && final_buffer_marker) ||
            (!host && rx_pid_valid && rx_is_data && rx_is_out
                && final_buffer_marker) ||
            (host && tx_setup_done && setup_no_data) ||
            (host && rx_pid_valid && rx_is_data && rx_is_in
                && (final_buffer_marker || rx_data_len_zero)) ||
            (host && tx_data_done && final_buffer_marker);
        set_v[USSF_SETUP_BIT] = !host && rx_pid_valid
            && rx_is_setup && !rx_is_data;
        set_v[USSF_ATTACH_BIT] = !host && line_connect;
        set_v[USSF_RESUME_BIT] = line_resume;
        set_v[USSF_SUSPEND_BIT] = line_suspend && !(host
            && (st_q.sie_ctrl[USSF_SOF_EN_BIT]
            || st_q.sie_ctrl[USSF_KEEP_EN_BIT]));
    end

    assign evt.set_vec = set_v;
    assign evt.clr_vec = (wr && reg_sel(paddr) == 2'h3)
        ? pwdata : 32'h0000_0000;

    ussf_flag_reg u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .evt(evt)
    );

    // Read-only live fields merged with the sticky flags
    always_comb begin
        live = evt.flags;
        live[USSF_OVERCUR_BIT] = supply_overcurrent_in;
        live[USSF_SPEED_LSB +: 2] = host ? st_q.speed
            : USSF_SPEED_NONE;
        live[USSF_LINE_LSB +: 2] = line_state;
        live[USSF_VBUS_BIT] = supply_present_in;
    end

    // Next state: registers, speed tracking, turnaround timer
    always_comb begin
        st_d = st_q;
        if (wr && reg_sel(paddr) == 2'h1) begin
            st_d.main_ctrl = pwdata;
        end
        if (wr && reg_sel(paddr) == 2'h2) begin
            st_d.sie_ctrl = pwdata;
        end
        // Read data captured in setup so it is stable in access
        if (psel && !penable && !pwrite) begin
            case (reg_sel(paddr))
                2'h1: st_d.rdata = st_q.main_ctrl;
                2'h2: st_d.rdata = st_q.sie_ctrl;
                2'h3: st_d.rdata = live;
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
        // Speed follows idle line polarity once attached
        if (!host || line_state == 2'h0) begin
            st_d.speed = USSF_SPEED_NONE;
        end else if (dev_low_speed || line_state == USSF_LINE_K) begin
            st_d.speed = USSF_SPEED_LS;
        end else if (line_state == USSF_LINE_J) begin
            st_d.speed = USSF_SPEED_FS;
        end
        // Setup seen arms the DATA0 check for the next data packet
        if (rx_pid_valid && rx_is_setup && !rx_is_data) begin
            st_d.setup_seen = 1'b1;
        end else if (rx_pid_valid && rx_is_data) begin
            st_d.setup_seen = 1'b0;
        end
        case (st_q.state)
            USSF_ST_IDLE: begin
                st_d.turn_cnt = 16'h0000;
                if (ack_expected) begin
                    st_d.state = USSF_ST_WAIT_ACK;
                end
            end
            USSF_ST_WAIT_ACK: begin
                st_d.turn_cnt = st_q.turn_cnt + 16'h0001;
                if ((rx_pid_valid && (rx_is_ack || rx_is_nak
                    || rx_is_stall)) || timeout) begin
                    st_d.state = USSF_ST_IDLE;
                end
            end
            default: st_d.state = USSF_ST_IDLE;
        endcase
    end

    // All state held while clock enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{main_ctrl: USSF_CTRL_RST, sie_ctrl: USSF_CTRL_RST,
                rdata: 32'h0000_0000, speed: USSF_SPEED_NONE,
                state: USSF_ST_IDLE, turn_cnt: 16'h0000,
                setup_seen: 1'b0};
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // Zero-wait slave; stalls only through the clock enable
    assign pready = clk_en;
    assign pslverr = access && reg_sel(paddr) == 2'h0;
    assign prdata = st_q.rdata;
    assign role_select_bit = host;
    assign bus_suspended = evt.flags[USSF_SUSPEND_BIT];
endmodule // ussf_status

/* File: verification/ussf_status_props.sv */
// Checker for the status block's bus answers and flag outputs
`timescale 1ns/1ps
module ussf_status_props
    import ussf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic line_suspend,
    input wire logic [1:0] line_state,
    input wire logic supply_present_in,
    input wire logic role_select_bit,
    input wire logic bus_suspended
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc, map, rds, clr4;
    // Access phase, mapped decode, read setup, suspend clear write
    assign acc = psel && penable && clk_en;
    assign map = paddr inside {USSF_STATUS_OFS, USSF_CTRL_OFS, USSF_MAIN_OFS};
    assign rds = psel && !penable && !pwrite && clk_en;
    assign clr4 = acc && pwrite && paddr == USSF_STATUS_OFS && pwdata[4];
    a_ready_follows_enable: assert property (pready == clk_en)
        else $error("pready differs from clk_en");
    a_unmapped_refused: assert property (acc && !map |-> pslverr)
        else $error("unmapped access not refused");
    a_unmapped_reads_zero: assert property (rds && !map |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_live_line_bits: assert property (
        rds && paddr == USSF_STATUS_OFS |=>
        prdata[3:2] == $past(line_state)
        && prdata[0] == $past(supply_present_in))
        else $error("line state or supply bit stale");
    a_suspend_sets: assert property (
        line_suspend && clk_en && !role_select_bit |=> bus_suspended)
        else $error("suspend event lost");
    a_suspend_clears: assert property (
        clr4 && !line_suspend |=> !bus_suspended)
        else $error("suspend flag not cleared");
    a_suspend_sticky: assert property (
        bus_suspended && !clr4 |=> bus_suspended)
        else $error("suspend flag dropped");
    a_role_follows_write: assert property (
        acc && pwrite && paddr == USSF_MAIN_OFS |=>
        role_select_bit == $past(pwdata[1]))
        else $error("role bit not written");
endmodule // ussf_status_props

/* File: verification/ussf_peer_model.sv */
// Bus peer model: presents one decoded packet per request
`timescale 1ns/1ps
module ussf_peer_model (
    input wire logic pclk,
    input wire logic go,
    input wire logic [2:0] op,
    output logic [7:0] pkt
);
    // Fields: valid setup out in data data1 zero-length ack
    // One-cycle pulse only, so no field lingers into the next packet
    always_ff @(posedge pclk) begin
        case (go ? op : 3'h7)
            3'h0: pkt <= 8'hC0; // SETUP token
            3'h1: pkt <= 8'hAC; // OUT DATA1
            3'h2: pkt <= 8'hA8; // OUT DATA0
            3'h3: pkt <= 8'h9C; // IN DATA1
            3'h4: pkt <= 8'h9A; // IN DATA0, zero length
            3'h5: pkt <= 8'h81; // ACK handshake
            default: pkt <= 8'h00;
        endcase
    end
endmodule // ussf_peer_model

/* File: verification/tb_usb_engine_status_word_flags.sv */
// Self-checking bench for the engine status word block
`timescale 1ns/1ps
module tb_usb_engine_status_word_flags
    import ussf_pkg::*;
;
    localparam int TURN = 8;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, go = 1'b0, pready, pslverr, serr, role, susp;
    logic cen = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [2:0] op = 3'h0;
    logic [7:0] pkt, lv = 8'h00;
    logic [9:0] ln = 10'h000;
    int error_cnt = 0, checks = 0, cyc = 0;
    always #10 pclk = ~pclk;
    // Packet-level events come from the peer, line events from ln
    ussf_peer_model u_peer (.pclk(pclk), .go(go), .op(op), .pkt(pkt));
    ussf_status #(.TURN_CYC(TURN)) u_dut (
        .pclk(pclk), .presetn(presetn), .clk_en(cen), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_pid_valid(pkt[7]), .rx_is_setup(pkt[6]), .rx_is_out(pkt[5]),
        .rx_is_in(pkt[4]), .rx_is_data(pkt[3]), .rx_data1(pkt[2]),
        .rx_data_len_zero(pkt[1]), .rx_is_ack(pkt[0]), .rx_is_nak(1'b0),
        .rx_is_stall(1'b0), .tx_data_done(ln[2]), .tx_setup_done(ln[1]),
        .setup_no_data(lv[7]), .ack_expected(ln[0]), .buf_toggle1(lv[6]),
        .final_buffer_marker(lv[5]), .rx_overrun(ln[9]),
        .rx_stuff_err(ln[8]), .rx_crc_err(ln[7]), .line_bus_reset(ln[6]),
        .line_resume(ln[5]), .line_suspend(ln[4]), .line_connect(ln[3]),
        .line_state(lv[4:3]), .dev_low_speed(lv[2]),
        .supply_overcurrent_in(lv[1]), .supply_present_in(lv[0]),
        .role_select_bit(role), .bus_suspended(susp));
    task automatic report_and_stop();
        $display("Mismatches %0d in %0d checks", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, idles a cycle after release
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Read and judge the status word, then clear all sticky flags
    task automatic st(input logic [31:0] exp);
        bus(1'b0, USSF_STATUS_OFS, 32'h0);
        check(rdat, exp);
        bus(1'b1, USSF_STATUS_OFS, 32'hFFFF_FFFF);
    endtask
    task automatic send(input logic [2:0] o);
        go <= 1'b1;
        op <= o;
        @(posedge pclk);
        go <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic pulse(input logic [9:0] b);
        ln <= b;
        @(posedge pclk);
        ln <= 10'h000;
        @(posedge pclk);
    endtask
    task automatic t_reset();
        bus(1'b0, USSF_MAIN_OFS, 32'h0);
        check(rdat, USSF_CTRL_RST);
        bus(1'b0, 12'h010, 32'h0);
        check({rdat[30:0], serr}, 32'h1);
        st(USSF_STATUS_RST);
    endtask
    // Each line event alone; a zero write must not clear it
    task automatic t_line_flags();
        int pos [7] = '{26, 25, 24, 19, 11, 4, 16};
        for (int i = 0; i < 7; i++) begin
            pulse(10'h200 >> i);
            bus(1'b1, USSF_STATUS_OFS, 32'h0);
            st(32'h1 << pos[i]);
        end
        st(32'h0);
    endtask
    // Clock enable low: a line event must leave no trace
    task automatic t_freeze();
        cen <= 1'b0;
        pulse(10'h010);
        check({31'h0, susp}, 32'h0);
        cen <= 1'b1;
        st(32'h0);
    endtask
    // Buffer toggle at DATA1 first, so only the setup rule can flag
    task automatic t_dev_packets();
        lv <= 8'h40;
        send(3'h0);
        send(3'h1);
        st(32'h8002_0000);
        lv <= 8'h00;
        send(3'h2);
        st(32'h0);
        send(3'h1);
        send(3'h5);
        st(32'hC000_0000);
        pulse(10'h004);
        st(32'h0);
        lv <= 8'h20;
        pulse(10'h004);
        st(32'h0004_0000);
        lv <= 8'h00;
    endtask
    task automatic t_timeout();
        pulse(10'h001);
        send(3'h5);
        repeat (2 * TURN) @(posedge pclk);
        st(32'h4000_0000);
        // Flag lands TURN cycles after the request; look one edge before
        pulse(10'h001);
        repeat (TURN - 2) @(posedge pclk);
        bus(1'b0, USSF_STATUS_OFS, 32'h0);
        check(rdat, 32'h0);
        st(32'h0800_0000);
    endtask
    task automatic t_host();
        logic [7:0] lvs [3] = '{8'h0B, 8'h10, 8'h00};
        logic [31:0] exp [3] = '{32'h605, 32'h108, 32'h0};
        bus(1'b1, USSF_MAIN_OFS, 32'h2);
        check({31'h0, role}, 32'h1);
        send(3'h3);
        st(32'h8000_0000);
        send(3'h4);
        st(32'h0004_0000);
        lv <= 8'h80;
        pulse(10'h002);
        st(32'h0004_0000);
        lv <= 8'h20;
        pulse(10'h004);
        st(32'h0004_0000);
        bus(1'b1, USSF_CTRL_OFS, 32'h200);
        pulse(10'h010);
        check({31'h0, susp}, 32'h0);
        st(32'h0);
        bus(1'b1, USSF_CTRL_OFS, 32'h0);
        pulse(10'h010);
        check({31'h0, susp}, 32'h1);
        st(32'h10);
        for (int i = 0; i < 3; i++) begin
            lv <= lvs[i];
            repeat (3) @(posedge pclk);
            st(exp[i]);
        end
    endtask
    // Reset, then the scenarios in order
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_line_flags();
        t_freeze();
        t_dev_packets();
        t_timeout();
        t_host();
        report_and_stop();
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
endmodule // tb_usb_engine_status_word_flags
bind ussf_status ussf_status_props u_props (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_suspend(line_suspend), .line_state(line_state),
    .supply_present_in(supply_present_in), .role_select_bit(role_select_bit),
    .bus_suspended(bus_suspended));
